// ==== rtl/dmsc_pkg.sv ====
package dmsc_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [13:0] IDX_DCNTL = 14'h3bec;
  localparam logic [13:0] IDX_DCNTH = 14'h3bed;
  localparam logic [13:0] IDX_DSZL = 14'h3bee;
  localparam logic [13:0] IDX_DSZH = 14'h3bef;
  localparam logic [13:0] IDX_DSAL = 14'h3bf0;
  localparam logic [13:0] IDX_DSAH = 14'h3bf1;
  localparam logic [13:0] IDX_SCNTL = 14'h3bf2;
  localparam logic [13:0] IDX_SCNTH = 14'h3bf3;
  localparam logic [13:0] IDX_SPTRL = 14'h3bf4;
  localparam logic [13:0] IDX_SPTRH = 14'h3bf5;
  localparam logic [13:0] IDX_SPTRU = 14'h3bf6;
  localparam logic [13:0] IDX_SSZL = 14'h3bf7;
  localparam logic [13:0] IDX_SSZH = 14'h3bf8;
  localparam logic [13:0] IDX_SSAL = 14'h3bf9;
  localparam logic [13:0] IDX_SSAH = 14'h3bfa;
  localparam logic [13:0] IDX_SSAU = 14'h3bfb;
  localparam logic [13:0] IDX_MODE = 14'h3bfc;
  localparam logic [13:0] IDX_RUN = 14'h3bfd;
  localparam logic [13:0] IDX_ASEL = 14'h3bfe;
  localparam logic [13:0] IDX_SSEL = 14'h3bff;

  // Field widths
  localparam int CNT_W = 12;
  localparam int SADR_W = 22;
  localparam int DADR_W = 16;

  // Mode control fields
  localparam int MODE_DST_STOP = 5;
  localparam int MODE_SRC_STOP = 0;

  // Run control fields
  localparam int RUN_EN = 7;
  localparam int RUN_SEN = 6;
  localparam int RUN_GO = 5;
  localparam int RUN_AEN = 2;
  localparam int RUN_FULL = 0;

  // Reset values, and the count value one
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
  localparam logic [SADR_W-1:0] SADR_RST = 22'h000000;
  localparam logic [DADR_W-1:0] DADR_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

  // Lag from a stop condition to the engine seeing it, in cycles
  localparam int STOP_LAG_CYC = 1;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } dmsc_state_t;

  typedef struct packed {
    logic valid;
    logic [SADR_W-1:0] addr;
  } dmsc_rd_t;

  typedef struct packed {
    logic valid;
    logic [DADR_W-1:0] addr;
    logic [7:0] data;
  } dmsc_wr_t;

endpackage : dmsc_pkg

// ==== rtl/dmsc_top.sv ====
// Overview of operation
// - A selected peripheral interrupt starts a message; software picks it.
// - Start source is sampled only while start trigger enable is set.
// - Clearing start trigger enable does not halt a running message.
// - Clearing transfer go pauses; setting it again resumes the message.
// - Byte held after a read is not written while go is clear.
// - Abort source is sampled only while abort trigger enable is set.
// - Abort clears go, start trigger enable and abort trigger enable.
// - Abort keeps all channel state so go resumes where it stopped.
// - Source count reload completes message; source stop bit halts.
// - Dest count reload completes message; dest stop bit halts.
// - A count leaving one reloads from its size; reads zero only when its size is zero.
// - Clearing enable hard-stops and returns the channel to defaults.
// - A stop takes effect one cycle late; one more access may occur.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module dmsc_top #(
  parameter int N_IRQ = 128
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Interrupt lines of on-chip peripherals
  input wire logic [N_IRQ-1:0] i_irq_lines,
  // Source read port
  output dmsc_pkg::dmsc_rd_t o_rd,
  input wire logic i_rd_ack,
  input wire logic [7:0] i_rd_data,
  // Destination write port
  output dmsc_pkg::dmsc_wr_t o_wr,
  input wire logic i_wr_ack,
  // Message completion pulses
  output logic o_src_done,
  output logic o_dst_done
);

  localparam int CW = dmsc_pkg::CNT_W;

  // Configuration
  logic [CW-1:0] ssz_reg;
  logic [CW-1:0] dsz_reg;
  logic [dmsc_pkg::SADR_W-1:0] ssa_reg;
  logic [dmsc_pkg::DADR_W-1:0] dsa_reg;
  logic [7:0] mode_reg;
  logic [7:0] ssel_reg;
  logic [7:0] asel_reg;

  // Run control
  logic en_reg;
  logic sen_reg;
  logic go_reg;
  logic aen_reg;
  logic run_reg;

  // Channel state
  dmsc_pkg::dmsc_state_t state_reg;
  logic [CW-1:0] scnt_reg;
  logic [CW-1:0] dcnt_reg;
  logic [dmsc_pkg::SADR_W-1:0] sptr_reg;
  logic [dmsc_pkg::DADR_W-1:0] dptr_reg;
  logic [7:0] buf_reg;
  logic full_reg;

  // Trigger sampling
  logic start_prev_reg;
  logic abort_prev_reg;
  logic start_lvl;
  logic abort_lvl;
  logic start_req;
  logic abort_req;
  logic [255:0] irq_ext;

  // Bus decode
  logic acc;
  logic wr_fire;
  logic [13:0] idx;
  logic aligned;
  logic hit;
  logic [7:0] rd_mux;
  logic [7:0] wd;
  logic rc_wr;

  // Engine events
  logic src_reload;
  logic dst_reload;
  logic stop_cnt;

  assign acc = i_psel & i_penable;
  assign wr_fire = acc & o_pready & i_pwrite;
  assign idx = i_paddr[15:2];
  assign aligned = (i_paddr[1:0] == 2'h0);
  assign wd = i_pwdata[7:0];
  assign rc_wr = wr_fire & hit & (idx == dmsc_pkg::IDX_RUN);

  always_comb begin
    hit = aligned;
    rd_mux = 8'h00;
    case (idx)
      dmsc_pkg::IDX_DCNTL: rd_mux = dcnt_reg[7:0];
      dmsc_pkg::IDX_DCNTH: rd_mux = {4'h0, dcnt_reg[11:8]};
      dmsc_pkg::IDX_DSZL: rd_mux = dsz_reg[7:0];
      dmsc_pkg::IDX_DSZH: rd_mux = {4'h0, dsz_reg[11:8]};
      dmsc_pkg::IDX_DSAL: rd_mux = dsa_reg[7:0];
      dmsc_pkg::IDX_DSAH: rd_mux = dsa_reg[15:8];
      dmsc_pkg::IDX_SCNTL: rd_mux = scnt_reg[7:0];
      dmsc_pkg::IDX_SCNTH: rd_mux = {4'h0, scnt_reg[11:8]};
      dmsc_pkg::IDX_SPTRL: rd_mux = sptr_reg[7:0];
      dmsc_pkg::IDX_SPTRH: rd_mux = sptr_reg[15:8];
      dmsc_pkg::IDX_SPTRU: rd_mux = {2'h0, sptr_reg[21:16]};
      dmsc_pkg::IDX_SSZL: rd_mux = ssz_reg[7:0];
      dmsc_pkg::IDX_SSZH: rd_mux = {4'h0, ssz_reg[11:8]};
      dmsc_pkg::IDX_SSAL: rd_mux = ssa_reg[7:0];
      dmsc_pkg::IDX_SSAH: rd_mux = ssa_reg[15:8];
      dmsc_pkg::IDX_SSAU: rd_mux = {2'h0, ssa_reg[21:16]};
      dmsc_pkg::IDX_MODE: rd_mux = mode_reg;
      dmsc_pkg::IDX_RUN: begin
        rd_mux = 8'h00;
        rd_mux[dmsc_pkg::RUN_EN] = en_reg;
        rd_mux[dmsc_pkg::RUN_SEN] = sen_reg;
        rd_mux[dmsc_pkg::RUN_GO] = go_reg;
        rd_mux[dmsc_pkg::RUN_AEN] = aen_reg;
        rd_mux[dmsc_pkg::RUN_FULL] = full_reg;
      end
      dmsc_pkg::IDX_ASEL: rd_mux = asel_reg;
      dmsc_pkg::IDX_SSEL: rd_mux = ssel_reg;
      default: hit = 1'b0;
    endcase
  end

  // One wait state on every access keeps the read mux off the timing path
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= acc & ~o_pready;
      if (acc & ~o_pready) begin
        o_prdata <= (hit & ~i_pwrite) ? {24'h000000, rd_mux} : 32'h0;
        o_pslverr <= ~hit;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ssz_reg <= dmsc_pkg::CNT_RST;
      dsz_reg <= dmsc_pkg::CNT_RST;
      ssa_reg <= dmsc_pkg::SADR_RST;
      dsa_reg <= dmsc_pkg::DADR_RST;
      mode_reg <= dmsc_pkg::BYTE_RST;
      ssel_reg <= dmsc_pkg::BYTE_RST;
      asel_reg <= dmsc_pkg::BYTE_RST;
    end else if (wr_fire & hit) begin
      case (idx)
        dmsc_pkg::IDX_DSZL: dsz_reg[7:0] <= wd;
        dmsc_pkg::IDX_DSZH: dsz_reg[11:8] <= wd[3:0];
        dmsc_pkg::IDX_DSAL: dsa_reg[7:0] <= wd;
        dmsc_pkg::IDX_DSAH: dsa_reg[15:8] <= wd;
        dmsc_pkg::IDX_SSZL: ssz_reg[7:0] <= wd;
        dmsc_pkg::IDX_SSZH: ssz_reg[11:8] <= wd[3:0];
        dmsc_pkg::IDX_SSAL: ssa_reg[7:0] <= wd;
        dmsc_pkg::IDX_SSAH: ssa_reg[15:8] <= wd;
        dmsc_pkg::IDX_SSAU: ssa_reg[21:16] <= wd[5:0];
        dmsc_pkg::IDX_MODE: mode_reg <= wd;
        dmsc_pkg::IDX_ASEL: asel_reg <= wd;
        dmsc_pkg::IDX_SSEL: ssel_reg <= wd;
        default: ;
      endcase
    end
  end

  // Lines above N_IRQ read as idle
  assign irq_ext = 256'(i_irq_lines);
  assign start_lvl = irq_ext[ssel_reg];
  assign abort_lvl = irq_ext[asel_reg];
  // A request is the rising edge of the selected line
  assign start_req = en_reg & sen_reg & start_lvl & ~start_prev_reg;
  assign abort_req = en_reg & aen_reg & abort_lvl & ~abort_prev_reg;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      start_prev_reg <= 1'b0;
      abort_prev_reg <= 1'b0;
    end else begin
      start_prev_reg <= start_lvl;
      abort_prev_reg <= abort_lvl;
    end
  end

  assign src_reload = (state_reg == dmsc_pkg::ST_READ) & o_rd.valid &
                      i_rd_ack & (scnt_reg == dmsc_pkg::CNT_ONE);
  assign dst_reload = (state_reg == dmsc_pkg::ST_WRITE) & o_wr.valid &
                      i_wr_ack & (dcnt_reg == dmsc_pkg::CNT_ONE);
  assign stop_cnt = (src_reload & mode_reg[dmsc_pkg::MODE_SRC_STOP]) |
                    (dst_reload & mode_reg[dmsc_pkg::MODE_DST_STOP]);

  // Later assignments take priority: start beats a software clear of go,
  // a count stop beats start, abort and hard-stop beat everything
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      en_reg <= 1'b0;
      sen_reg <= 1'b0;
      go_reg <= 1'b0;
      aen_reg <= 1'b0;
    end else begin
      if (rc_wr) begin
        en_reg <= wd[dmsc_pkg::RUN_EN];
        sen_reg <= wd[dmsc_pkg::RUN_SEN];
        go_reg <= wd[dmsc_pkg::RUN_GO] & wd[dmsc_pkg::RUN_EN];
        aen_reg <= wd[dmsc_pkg::RUN_AEN];
      end
      if (start_req) begin
        go_reg <= 1'b1;
      end
      if (stop_cnt) begin
        go_reg <= 1'b0;
      end
      if (abort_req) begin
        go_reg <= 1'b0;
        sen_reg <= 1'b0;
        aen_reg <= 1'b0;
      end
      if (rc_wr & ~wd[dmsc_pkg::RUN_EN]) begin
        sen_reg <= 1'b0;
        go_reg <= 1'b0;
        aen_reg <= 1'b0;
      end
    end
  end

  // The engine sees go one cycle late, so a stop lets one access through
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_reg <= 1'b0;
    end else begin
      run_reg <= go_reg;
    end
  end

  // Abort and soft-stop touch nothing here; only enable low reloads
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= dmsc_pkg::ST_IDLE;
      scnt_reg <= dmsc_pkg::CNT_RST;
      dcnt_reg <= dmsc_pkg::CNT_RST;
      sptr_reg <= dmsc_pkg::SADR_RST;
      dptr_reg <= dmsc_pkg::DADR_RST;
      buf_reg <= dmsc_pkg::BYTE_RST;
      full_reg <= 1'b0;
      o_rd <= '0;
      o_wr <= '0;
    end else if (!en_reg) begin
      // An outstanding bus request is dropped on a hard-stop
      state_reg <= dmsc_pkg::ST_IDLE;
      scnt_reg <= ssz_reg;
      dcnt_reg <= dsz_reg;
      sptr_reg <= ssa_reg;
      dptr_reg <= dsa_reg;
      full_reg <= 1'b0;
      o_rd <= '0;
      o_wr <= '0;
    end else begin
      case (state_reg)
        dmsc_pkg::ST_IDLE: begin
          if (run_reg) begin
            state_reg <= dmsc_pkg::ST_READ;
          end
        end
        dmsc_pkg::ST_READ: begin
          if (o_rd.valid) begin
            if (i_rd_ack) begin
              o_rd.valid <= 1'b0;
              buf_reg <= i_rd_data;
              full_reg <= 1'b1;
              state_reg <= dmsc_pkg::ST_WRITE;
              if (scnt_reg == dmsc_pkg::CNT_ONE) begin
                scnt_reg <= ssz_reg;
                sptr_reg <= ssa_reg;
              end else begin
                scnt_reg <= scnt_reg - dmsc_pkg::CNT_ONE;
                sptr_reg <= sptr_reg + 22'h000001;
              end
            end
          end else if (run_reg) begin
            o_rd.valid <= 1'b1;
            o_rd.addr <= sptr_reg;
          end
        end
        dmsc_pkg::ST_WRITE: begin
          if (o_wr.valid) begin
            if (i_wr_ack) begin
              o_wr.valid <= 1'b0;
              full_reg <= 1'b0;
              state_reg <= dmsc_pkg::ST_READ;
              if (dcnt_reg == dmsc_pkg::CNT_ONE) begin
                dcnt_reg <= dsz_reg;
                dptr_reg <= dsa_reg;
              end else begin
                dcnt_reg <= dcnt_reg - dmsc_pkg::CNT_ONE;
                dptr_reg <= dptr_reg + 16'h0001;
              end
            end
          end else if (run_reg) begin
            // Held byte waits here while go is clear
            o_wr.valid <= 1'b1;
            o_wr.addr <= dptr_reg;
            o_wr.data <= buf_reg;
          end
        end
        default: state_reg <= dmsc_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_src_done <= 1'b0;
      o_dst_done <= 1'b0;
    end else begin
      o_src_done <= src_reload;
      o_dst_done <= dst_reload;
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_go_drop;
    $fell(go_reg);
  endsequence
  sequence s_run_tail;
    run_reg ##1 !run_reg;
  endsequence
  sequence s_src_wrap;
    src_reload ##1 (scnt_reg == $past(ssz_reg));
  endsequence

  a_start_sets_go: assert property (
    start_req && !stop_cnt && !abort_req && !rc_wr |=> go_reg ##1 run_reg)
    else $error("start request did not set go");
  a_go_cause: assert property (
    $rose(go_reg) |-> $past(start_req) || $past(rc_wr))
    else $error("go rose without start request or write");
  a_sen_no_halt: assert property (
    rc_wr && wd[dmsc_pkg::RUN_EN] && wd[dmsc_pkg::RUN_GO] &&
    !wd[dmsc_pkg::RUN_SEN] && !abort_req && !stop_cnt |=> go_reg)
    else $error("clearing start enable halted message");
  a_abort_clears: assert property (
    abort_req |=> !go_reg && !sen_reg && !aen_reg)
    else $error("abort left control bits set");
  a_abort_gated: assert property (
    go_reg && !aen_reg && !rc_wr && !stop_cnt |=> go_reg)
    else $error("go dropped while abort sampling disabled");
  a_pause_keeps: assert property (
    en_reg && !run_reg && !o_rd.valid && !o_wr.valid
    |=> $stable(scnt_reg) && $stable(dcnt_reg) && $stable(buf_reg))
    else $error("channel state changed while paused");
  a_held_byte: assert property (
    en_reg && state_reg == dmsc_pkg::ST_WRITE && !run_reg && !o_wr.valid
    |=> !o_wr.valid && full_reg)
    else $error("held byte written while go clear");
  a_count_wrap: assert property (
    src_reload |-> s_src_wrap)
    else $error("source count not reloaded from size");
  a_count_stop: assert property (
    stop_cnt |=> !go_reg ##1 !run_reg)
    else $error("count stop did not halt message");
  a_dst_done: assert property (
    dst_reload |=> o_dst_done ##1 !o_dst_done)
    else $error("dest completion pulse wrong");
  a_hard_stop: assert property (
    rc_wr && !wd[dmsc_pkg::RUN_EN]
    |=> !go_reg && !en_reg ##1 state_reg == dmsc_pkg::ST_IDLE &&
        scnt_reg == $past(ssz_reg, 1))
    else $error("hard stop did not return to defaults");
  a_stop_lag: assert property (
    s_go_drop |-> s_run_tail)
    else $error("stop lag not one cycle");
  a_apb_wait: assert property (
    acc && !o_pready |=> o_pready ##1 !o_pready)
    else $error("bus ready not one cycle after wait");

endmodule : dmsc_top

`default_nettype wire

// ==== tb/dma_message_start_stop_control_test.sv ====
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  num_errors++; $display("ERROR %0t: got %h expected %h", $time, (a), (b)); \
  end end

module dma_message_start_stop_control_test;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [127:0] irq_lines = '0;
  logic [3:0] lat = 4'h6;
  logic pready, pslverr, rd_ack, wr_ack, src_done, dst_done;
  logic [31:0] prdata, prd;
  logic perr;
  logic [7:0] rd_data, wr_cnt, last_data, n1;
  logic [15:0] last_addr;
  dmsc_pkg::dmsc_rd_t rd;
  dmsc_pkg::dmsc_wr_t wr;
  int num_errors = 0;
  int check_count = 0;
  int done_cnt = 0;
  int src_cnt = 0;
  int d0;

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (dst_done === 1'b1) done_cnt <= done_cnt + 1;
    if (src_done === 1'b1) src_cnt <= src_cnt + 1;
  end

  dmsc_top dut (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_irq_lines(irq_lines), .o_rd(rd),
    .i_rd_ack(rd_ack), .i_rd_data(rd_data), .o_wr(wr),
    .i_wr_ack(wr_ack), .o_src_done(src_done), .o_dst_done(dst_done));

  dmsc_mem_model mem (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_lat(lat),
    .i_rd(rd), .i_wr(wr), .o_rd_ack(rd_ack), .o_rd_data(rd_data),
    .o_wr_ack(wr_ack), .o_wr_cnt(wr_cnt), .o_last_addr(last_addr),
    .o_last_data(last_data));

  task automatic wrap_up;
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic apb(input logic w, input logic [13:0] idx,
                     input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    prd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    if (n >= 50) begin
      num_errors++;
      $display("ERROR %0t: bus access never answered", $time);
      wrap_up();
    end
  endtask : apb

  task automatic rc(input logic [13:0] idx, input logic [7:0] m,
                    input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    `CHK(prd & {24'hffffff, m}, {24'h000000, e})
  endtask : rc

  task automatic irq(input int k);
    irq_lines[k] <= 1'b1;
    @(posedge sys_clk);
    irq_lines[k] <= 1'b0;
    @(posedge sys_clk);
  endtask : irq

  task automatic wait_done(input int seen);
    int n;
    n = 0;
    while (done_cnt == seen && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 2000) begin
      num_errors++;
      $display("ERROR %0t: message never completed", $time);
      wrap_up();
    end
  endtask : wait_done

  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rc(dmsc_pkg::IDX_RUN, 8'hff, 8'h00);
    rc(dmsc_pkg::IDX_MODE, 8'hff, 8'h00);
    rc(dmsc_pkg::IDX_SSEL, 8'hff, 8'h00);
    rc(dmsc_pkg::IDX_ASEL, 8'hff, 8'h00);
    apb(1'b0, 14'h0000, 8'h00);
    `CHK({perr, prd}, 33'h100000000)
    // Stop on the destination reload so the message cannot overrun
    apb(1'b1, dmsc_pkg::IDX_MODE, 8'h20);
    apb(1'b1, dmsc_pkg::IDX_SSZL, 8'h02);
    apb(1'b1, dmsc_pkg::IDX_DSZL, 8'h02);
    apb(1'b1, dmsc_pkg::IDX_SSAL, 8'h10);
    apb(1'b1, dmsc_pkg::IDX_DSAL, 8'h40);
    apb(1'b1, dmsc_pkg::IDX_SSEL, 8'h05);
    apb(1'b1, dmsc_pkg::IDX_ASEL, 8'h06);
    apb(1'b1, dmsc_pkg::IDX_SCNTL, 8'h55);
    rc(dmsc_pkg::IDX_SCNTL, 8'hff, 8'h02);
    apb(1'b1, dmsc_pkg::IDX_RUN, 8'h80);
    irq(5);
    rc(dmsc_pkg::IDX_RUN, 8'hff, 8'h80);
    apb(1'b1, dmsc_pkg::IDX_RUN, 8'hc0);
    irq(6);
    rc(dmsc_pkg::IDX_RUN, 8'hff, 8'hc0);
    d0 = done_cnt;
    irq(5);
    rc(dmsc_pkg::IDX_RUN, 8'hfe, 8'he0);
    apb(1'b1, dmsc_pkg::IDX_RUN, 8'ha0);
    wait_done(d0);
    repeat (10) @(posedge sys_clk);
    `CHK({wr_cnt, last_addr, last_data}, 32'h0200414b)
    `CHK(src_cnt, 1)
    rc(dmsc_pkg::IDX_RUN, 8'hfe, 8'h80);
    rc(dmsc_pkg::IDX_DCNTL, 8'hff, 8'h02);
    // Go is still seen for one cycle after the stop, so one read slips out
    rc(dmsc_pkg::IDX_SCNTL, 8'hff, 8'h01);
    apb(1'b1, dmsc_pkg::IDX_RUN, 8'h00);
    rc(dmsc_pkg::IDX_RUN, 8'hff, 8'h00);
    rc(dmsc_pkg::IDX_SPTRL, 8'hff, 8'h10);
    // Both stops: the last write still lands, but no read follows it
    apb(1'b1, dmsc_pkg::IDX_MODE, 8'h21);
    apb(1'b1, dmsc_pkg::IDX_SSZL, 8'h08);
    apb(1'b1, dmsc_pkg::IDX_DSZL, 8'h08);
    lat <= 4'h1;
    apb(1'b1, dmsc_pkg::IDX_RUN, 8'hc4);
    d0 = done_cnt;
    irq(5);
    repeat (10) @(posedge sys_clk);
    irq(6);
    repeat (6) @(posedge sys_clk);
    n1 = wr_cnt;
    repeat (20) @(posedge sys_clk);
    `CHK(wr_cnt, n1)
    `CHK(n1 < 8'h0a, 1'b1)
    rc(dmsc_pkg::IDX_RUN, 8'hfe, 8'h80);
    apb(1'b1, dmsc_pkg::IDX_RUN, 8'ha0);
    repeat (2) @(posedge sys_clk);
    apb(1'b1, dmsc_pkg::IDX_RUN, 8'h80);
    repeat (4) @(posedge sys_clk);
    n1 = wr_cnt;
    repeat (20) @(posedge sys_clk);
    `CHK(wr_cnt, n1)
    apb(1'b1, dmsc_pkg::IDX_RUN, 8'ha0);
    wait_done(d0);
    repeat (10) @(posedge sys_clk);
    `CHK({last_addr, last_data}, 24'h00474d)
    `CHK(src_cnt, 2)
    rc(dmsc_pkg::IDX_SCNTL, 8'hff, 8'h08);
    rc(dmsc_pkg::IDX_DCNTL, 8'hff, 8'h08);
    wrap_up();
  end
endmodule : dma_message_start_stop_control_test

`default_nettype wire

// ==== tb/dmsc_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module dmsc_mem_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Answer latency in cycles
  input wire logic [3:0] i_lat,
  // Engine memory ports
  input wire dmsc_pkg::dmsc_rd_t i_rd,
  input wire dmsc_pkg::dmsc_wr_t i_wr,
  output logic o_rd_ack,
  output logic [7:0] o_rd_data,
  output logic o_wr_ack,
  // Observed writes
  output logic [7:0] o_wr_cnt,
  output logic [15:0] o_last_addr,
  output logic [7:0] o_last_data
);
  logic [3:0] wait_reg;
  logic [7:0] noise_reg;

  assign o_rd_ack = i_rd.valid && (wait_reg >= i_lat);
  assign o_wr_ack = i_wr.valid && (wait_reg >= i_lat);
  // Outside the ack cycle the bus moves, so a stale byte never looks valid
  assign o_rd_data = o_rd_ack ? (i_rd.addr[7:0] ^ 8'h5a) : noise_reg;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_reg <= 4'h0;
      noise_reg <= 8'h00;
    end else begin
      noise_reg <= noise_reg + 8'h3b;
      if ((i_rd.valid && !o_rd_ack) || (i_wr.valid && !o_wr_ack)) begin
        wait_reg <= wait_reg + 4'h1;
      end else begin
        wait_reg <= 4'h0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_wr_cnt <= 8'h00;
      o_last_addr <= 16'h0000;
      o_last_data <= 8'h00;
    end else if (o_wr_ack) begin
      o_wr_cnt <= o_wr_cnt + 8'h01;
      o_last_addr <= i_wr.addr;
      o_last_data <= i_wr.data;
    end
  end
endmodule : dmsc_mem_model

`default_nettype wire
